// [adcsm_pkg.sv]
package adcsm_pkg;

  // ---------------------------------------------------------------
  // Pins and register map
  // ---------------------------------------------------------------
  localparam int PIN_W = 4;
  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_CONVERSION_CLOCK = 3;
  localparam logic [3:0] PIN_RST = 4'h1;

  localparam logic [4:0] OFS_STAT = 5'h00;
  localparam logic [4:0] OFS_SAMPLE = 5'h04;
  localparam logic [4:0] OFS_MEAS = 5'h08;
  localparam logic [4:0] OFS_TERMS = 5'h0c;
  localparam logic [4:0] OFS_RESULT = 5'h10;
  localparam int MEAS_GAIN_LSB = 16;
  localparam int RESULT_CHAN_LSB = 16;

  // ---------------------------------------------------------------
  // Instruction set and timing counts
  // ---------------------------------------------------------------
  localparam int INSTR_BITS = 8;
  localparam logic [2:0] OP_CONV = 3'h0;
  localparam logic [2:0] OP_CAL = 3'h1;
  localparam logic [2:0] OP_ZERO = 3'h2;
  localparam logic [2:0] OP_PUP = 3'h3;
  localparam logic [2:0] OP_PDN = 3'h4;
  localparam logic [2:0] OP_CFG = 3'h5;

  localparam logic [11:0] ACQ_P0 = 12'h006;
  localparam logic [11:0] ACQ_P1 = 12'h00a;
  localparam logic [11:0] ACQ_P2 = 12'h012;
  localparam logic [11:0] ACQ_P3 = 12'h022;
  localparam logic [11:0] CONV_PERIODS = 12'h02c;
  localparam logic [11:0] ZERO_PERIODS = 12'h04c;
  localparam logic [11:0] CAL_PERIODS = 12'h574;

  localparam logic [4:0] LEN_BASE = 5'h0c;
  localparam logic [4:0] LEN_SIGN = 5'h01;
  localparam logic [4:0] LEN_LONG = 5'h04;
  localparam logic signed [13:0] GAIN_UNITY = 14'sh1000;
  localparam logic signed [15:0] RES_MAX = 16'sh0fff;
  localparam logic signed [15:0] RES_MIN = -16'sh1000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ACQ = 3'h1,
    ST_CONV = 3'h3,
    ST_CAL = 3'h4,
    ST_ZERO = 3'h5
  } adcsm_state_t;

  typedef struct packed {
    logic conversion_clock;
    logic serial_instruction_in;
    logic sclk;
    logic cs_n;
  } adcsm_pin_t;

  typedef struct packed {
    logic user_mode;
    logic pwr_dn;
    logic [2:0] chan;
    logic lsb_first;
    logic long_w;
    logic sign_off;
    logic [1:0] acq_sel;
  } adcsm_cfg_t;

  localparam adcsm_cfg_t CFG_RST = '{user_mode: 1'b1, pwr_dn: 1'b0, chan: 3'h0, lsb_first: 1'b0,
                                     long_w: 1'b0, sign_off: 1'b0, acq_sel: 2'h1};

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] q;
  } adcsm_sync_st_t;

  typedef struct packed {
    logic [12:0] off;
    logic [11:0] gain;
    logic valid;
    logic [12:0] res;
  } adcsm_corr_st_t;

  typedef struct packed {
    adcsm_state_t st;
    logic [11:0] cnt;
    adcsm_cfg_t cfg;
    logic [3:0] prev;
    logic [7:0] instr;
    logic [4:0] bit_cnt;
    logic exec_done;
    logic [4:0] frame_len;
    logic [16:0] out_sh;
    logic dout;
    logic oe;
    logic ack;
    logic [31:0] rdata;
    logic [12:0] sample;
    logic [31:0] meas;
    logic [2:0] res_chan;
  } adcsm_main_st_t;

endpackage

// [adcsm_sync3.sv]
`timescale 1ns/10ps
module adcsm_sync3 (
  input wire clk_sys,
  input wire nrst,
  input wire [adcsm_pkg::PIN_W-1:0] d,
  output logic [adcsm_pkg::PIN_W-1:0] q
);

  adcsm_pkg::adcsm_sync_st_t s_r;
  adcsm_pkg::adcsm_sync_st_t s_nxt;

  // A level counts only once the second and third stages agree
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    for (int i = 0; i < adcsm_pkg::PIN_W; i++) begin
      if (s_r.s2[i] == s_r.s3[i]) begin
        s_nxt.q[i] = s_r.s2[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_r <= {4{adcsm_pkg::PIN_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;

endmodule

// [adcsm_corr.sv]
`timescale 1ns/10ps
module adcsm_corr (
  input wire clk_sys,
  input wire nrst,
  input wire cal_go,
  input wire zero_go,
  input wire conv_go,
  input wire [12:0] meas_off,
  input wire [11:0] meas_gain,
  input wire [12:0] raw,
  output logic [12:0] off_term,
  output logic [11:0] gain_term,
  output logic cal_valid,
  output logic [12:0] result
);

  adcsm_pkg::adcsm_corr_st_t s_r;
  adcsm_pkg::adcsm_corr_st_t s_nxt;
  logic signed [13:0] diff;
  logic signed [13:0] gmul;
  logic signed [27:0] prod;
  logic signed [15:0] scaled;

  assign diff = $signed({raw[12], raw}) - $signed({s_r.off[12], s_r.off});
  assign gmul = adcsm_pkg::GAIN_UNITY + $signed({{2{s_r.gain[11]}}, s_r.gain});
  assign prod = diff * gmul;
  assign scaled = prod[27:12];

  always_comb begin
    s_nxt = s_r;
    if (cal_go) begin
      s_nxt.off = meas_off;
      s_nxt.gain = meas_gain;
      s_nxt.valid = 1'b1;
    end
    if (zero_go) begin
      s_nxt.off = meas_off;
    end
    if (conv_go) begin
      if (scaled > adcsm_pkg::RES_MAX) begin
        s_nxt.res = adcsm_pkg::RES_MAX[12:0];
      end else if (scaled < adcsm_pkg::RES_MIN) begin
        s_nxt.res = adcsm_pkg::RES_MIN[12:0];
      end else begin
        s_nxt.res = scaled[12:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign off_term = s_r.off;
  assign gain_term = s_r.gain;
  assign cal_valid = s_r.valid;
  assign result = s_r.res;

  cal_store_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    cal_go |=> (s_r.off == $past(meas_off)) && (s_r.gain == $past(meas_gain)) && s_r.valid)
    else $error("calibration terms not stored");

  zero_only_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (zero_go && !cal_go) |=> $stable(s_r.gain) && (s_r.off == $past(meas_off)))
    else $error("offset zeroing touched gain or missed offset");

endmodule

// [adcsm_top.sv]
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// - Calibration measures offset and gain terms, stores them and applies them to every conversion.
// - Offset zeroing re-measures only the offset term, separately from a full calibration.
// - After reset the mode is no calibration, no zeroing, 10-period acquisition, 12 bits, signed, powered, MSB first.
// - Calibrate, zero, power-up and power-down instructions leave acquisition, sign and output format as they were.
// - An all-zero instruction converts channel pair zero/one with 12 bits and MSB-first output of 13 bits when signed, 12 with sign off.
// - Output words are 12, 13, 16 or 17 bits long as the format selects.
// - Acquisition starts at a shift clock falling edge and ends on a conversion clock rising edge.
// - Acquisition lasts 6, 10, 18 or 34 conversion clock periods as programmed.
module adcsm_top (
  input wire clk_sys,
  input wire nrst,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire adcsm_pkg::adcsm_pin_t pins,
  output logic data_out,
  output logic data_oe
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [11:0] acq_len(input logic [1:0] sel);
    case (sel)
      2'h0: acq_len = adcsm_pkg::ACQ_P0;
      2'h1: acq_len = adcsm_pkg::ACQ_P1;
      2'h2: acq_len = adcsm_pkg::ACQ_P2;
      default: acq_len = adcsm_pkg::ACQ_P3;
    endcase
  endfunction

  function automatic logic [4:0] word_len(input adcsm_pkg::adcsm_cfg_t c);
    word_len = adcsm_pkg::LEN_BASE;
    if (!c.sign_off) begin
      word_len = word_len + adcsm_pkg::LEN_SIGN;
    end
    if (c.long_w) begin
      word_len = word_len + adcsm_pkg::LEN_LONG;
    end
  endfunction

  // Left-justified word; long formats pad zeros after the value, before it when LSB first
  function automatic logic [16:0] word_build(input logic [12:0] res, input adcsm_pkg::adcsm_cfg_t c);
    logic [16:0] w;
    logic [4:0] n;
    w = c.sign_off ? {res[11:0], 5'h00} : {res, 4'h0};
    n = word_len(c);
    word_build = w;
    if (c.lsb_first) begin
      for (int i = 0; i < 17; i++) begin
        if (i < int'(n)) begin
          word_build[16-i] = w[17-int'(n)+i];
        end
      end
    end
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    be_merge = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        be_merge[8*b +: 8] = wd[8*b +: 8];
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // Pin synchroniser and correction store
  // ---------------------------------------------------------------
  logic [3:0] pq;
  logic cal_go;
  logic zero_go;
  logic conv_go;
  logic [12:0] off_term;
  logic [11:0] gain_term;
  logic cal_valid;
  logic [12:0] result;
  adcsm_pkg::adcsm_main_st_t s_r;
  adcsm_pkg::adcsm_main_st_t s_nxt;

  adcsm_sync3 u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d(pins),
    .q(pq)
  );

  adcsm_corr u_corr (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .cal_go(cal_go),
    .zero_go(zero_go),
    .conv_go(conv_go),
    .meas_off(s_r.meas[12:0]),
    .meas_gain(s_r.meas[adcsm_pkg::MEAS_GAIN_LSB +: 12]),
    .raw(s_r.sample),
    .off_term(off_term),
    .gain_term(gain_term),
    .cal_valid(cal_valid),
    .result(result)
  );

  // ---------------------------------------------------------------
  // Link edges
  // ---------------------------------------------------------------
  logic cs_act;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic conversion_clock_rise;
  logic exec;
  logic [2:0] op;
  logic req;
  logic [11:0] acq_tgt;

  assign cs_act = !pq[adcsm_pkg::PIN_CS];
  assign cs_fall = !pq[adcsm_pkg::PIN_CS] && s_r.prev[adcsm_pkg::PIN_CS];
  assign cs_rise = pq[adcsm_pkg::PIN_CS] && !s_r.prev[adcsm_pkg::PIN_CS];
  assign sclk_rise = pq[adcsm_pkg::PIN_SCLK] && !s_r.prev[adcsm_pkg::PIN_SCLK];
  assign sclk_fall = !pq[adcsm_pkg::PIN_SCLK] && s_r.prev[adcsm_pkg::PIN_SCLK];
  assign conversion_clock_rise = pq[adcsm_pkg::PIN_CONVERSION_CLOCK] && !s_r.prev[adcsm_pkg::PIN_CONVERSION_CLOCK];
  assign exec = cs_act && sclk_fall && !s_r.exec_done &&
                (s_r.bit_cnt == 5'(adcsm_pkg::INSTR_BITS));
  assign op = s_r.instr[7:5];
  assign req = avs_read || avs_write;
  assign acq_tgt = acq_len(s_r.cfg.acq_sel);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = pq;
    cal_go = 1'b0;
    zero_go = 1'b0;
    conv_go = 1'b0;

    // Frame start loads the word with the format now in force
    if (cs_fall) begin
      s_nxt.bit_cnt = 5'h00;
      s_nxt.exec_done = 1'b0;
      s_nxt.frame_len = word_len(s_r.cfg);
      s_nxt.out_sh = word_build(result, s_r.cfg);
      s_nxt.dout = s_nxt.out_sh[16];
      s_nxt.oe = 1'b1;
    end
    if (cs_rise) begin
      s_nxt.oe = 1'b0;
    end
    if (cs_act && sclk_rise) begin
      if (s_r.bit_cnt < 5'(adcsm_pkg::INSTR_BITS)) begin
        s_nxt.instr[s_r.bit_cnt[2:0]] = pq[adcsm_pkg::PIN_SDI];
      end
      if (s_r.bit_cnt != 5'h1f) begin
        s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
      end
    end
    // word shifted out for its own length
    if (cs_act && sclk_fall && s_r.bit_cnt != 5'h00 && s_r.bit_cnt < s_r.frame_len) begin
      s_nxt.out_sh = {s_r.out_sh[15:0], 1'b0};
      s_nxt.dout = s_r.out_sh[15];
    end

    // only convert and config touch the format
    if (exec) begin
      s_nxt.exec_done = 1'b1;
      case (op)
        adcsm_pkg::OP_CONV: begin
          // zero fields give pair zero/one, short MSB first
          s_nxt.cfg.chan = s_r.instr[2:0];
          s_nxt.cfg.long_w = s_r.instr[3];
          s_nxt.cfg.lsb_first = s_r.instr[4];
        end
        adcsm_pkg::OP_PUP: s_nxt.cfg.pwr_dn = 1'b0;
        adcsm_pkg::OP_PDN: s_nxt.cfg.pwr_dn = 1'b1;
        adcsm_pkg::OP_CFG: begin
          s_nxt.cfg.acq_sel = s_r.instr[1:0];
          s_nxt.cfg.sign_off = s_r.instr[2];
        end
        default: s_nxt.cfg = s_r.cfg;
      endcase
    end

    // Requests while busy are dropped; the host sees no error
    case (s_r.st)
      adcsm_pkg::ST_IDLE: begin
        s_nxt.cnt = 12'h000;
        if (exec && op == adcsm_pkg::OP_CONV && !s_r.cfg.pwr_dn) begin
          // acquisition opens at the shift clock fall
          s_nxt.st = adcsm_pkg::ST_ACQ;
        end else if (exec && op == adcsm_pkg::OP_CAL) begin
          s_nxt.st = adcsm_pkg::ST_CAL;
        end else if (exec && op == adcsm_pkg::OP_ZERO) begin
          s_nxt.st = adcsm_pkg::ST_ZERO;
        end
      end
      adcsm_pkg::ST_ACQ: begin
        if (conversion_clock_rise) begin
          if (s_r.cnt == acq_tgt - 12'h001) begin
            s_nxt.st = adcsm_pkg::ST_CONV;
            s_nxt.cnt = 12'h000;
          end else begin
            s_nxt.cnt = s_r.cnt + 12'h001;
          end
        end
      end
      adcsm_pkg::ST_CONV: begin
        if (conversion_clock_rise) begin
          if (s_r.cnt == adcsm_pkg::CONV_PERIODS - 12'h001) begin
            s_nxt.st = adcsm_pkg::ST_IDLE;
            s_nxt.res_chan = s_r.cfg.chan;
            conv_go = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt + 12'h001;
          end
        end
      end
      adcsm_pkg::ST_CAL: begin
        if (conversion_clock_rise) begin
          if (s_r.cnt == adcsm_pkg::CAL_PERIODS - 12'h001) begin
            s_nxt.st = adcsm_pkg::ST_IDLE;
            cal_go = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt + 12'h001;
          end
        end
      end
      adcsm_pkg::ST_ZERO: begin
        if (conversion_clock_rise) begin
          if (s_r.cnt == adcsm_pkg::ZERO_PERIODS - 12'h001) begin
            s_nxt.st = adcsm_pkg::ST_IDLE;
            zero_go = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt + 12'h001;
          end
        end
      end
      default: s_nxt.st = adcsm_pkg::ST_IDLE;
    endcase

    // Two-cycle slave: read data is latched as the request lands
    if (s_r.ack) begin
      s_nxt.ack = 1'b0;
      if (avs_write) begin
        case (avs_address)
          adcsm_pkg::OFS_SAMPLE: s_nxt.sample = 13'(be_merge({19'h0, s_r.sample}, avs_writedata, avs_byteenable));
          adcsm_pkg::OFS_MEAS: s_nxt.meas = be_merge(s_r.meas, avs_writedata, avs_byteenable) &
                                            32'h0fff_1fff;
          default: s_nxt.meas = s_r.meas;
        endcase
      end
    end else if (req) begin
      s_nxt.ack = 1'b1;
      case (avs_address)
        adcsm_pkg::OFS_STAT: s_nxt.rdata = {17'h0, s_r.st != adcsm_pkg::ST_IDLE, s_r.st, cal_valid, s_r.cfg};
        adcsm_pkg::OFS_SAMPLE: s_nxt.rdata = {19'h0, s_r.sample};
        adcsm_pkg::OFS_MEAS: s_nxt.rdata = s_r.meas;
        adcsm_pkg::OFS_TERMS: s_nxt.rdata = {4'h0, gain_term, 3'h0, off_term};
        adcsm_pkg::OFS_RESULT: s_nxt.rdata = {13'h0, s_r.res_chan, 3'h0, result};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{st: adcsm_pkg::ST_IDLE, cfg: adcsm_pkg::CFG_RST, prev: adcsm_pkg::PIN_RST, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_waitrequest = req && !s_r.ack;
  assign avs_readdata = s_r.rdata;
  assign data_out = s_r.dout;
  assign data_oe = s_r.oe;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  acq_len_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (s_r.st == adcsm_pkg::ST_ACQ ##1 s_r.st == adcsm_pkg::ST_CONV) |->
      ($past(s_r.cnt) == $past(acq_tgt) - 12'h001) && $past(conversion_clock_rise))
    else $error("acquisition length wrong");

  acq_start_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (s_r.st == adcsm_pkg::ST_IDLE ##1 s_r.st == adcsm_pkg::ST_ACQ) |-> $past(sclk_fall) && $past(exec))
    else $error("acquisition began off a shift clock fall");

  cfg_keep_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (exec && (op == adcsm_pkg::OP_CAL || op == adcsm_pkg::OP_ZERO || op == adcsm_pkg::OP_PUP ||
              op == adcsm_pkg::OP_PDN)) |=>
      (s_r.cfg.acq_sel == $past(s_r.cfg.acq_sel)) && (s_r.cfg.sign_off == $past(s_r.cfg.sign_off)) &&
      (s_r.cfg.long_w == $past(s_r.cfg.long_w)) && (s_r.cfg.lsb_first == $past(s_r.cfg.lsb_first)))
    else $error("configuration changed by a non-config instruction");

  rst_cfg_a: assert property (@(posedge clk_sys)
    $rose(nrst) |-> (s_r.cfg == adcsm_pkg::CFG_RST) && (s_r.st == adcsm_pkg::ST_IDLE) && !cal_valid)
    else $error("reset configuration wrong");

  zero_instr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (exec && s_r.instr == 8'h00) |=> (s_r.cfg.chan == 3'h0) && !s_r.cfg.long_w && !s_r.cfg.lsb_first)
    else $error("all-zero instruction mis-decoded");

  word_len_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    cs_fall |=> (s_r.frame_len == 5'h0c || s_r.frame_len == 5'h0d || s_r.frame_len == 5'h10 ||
                 s_r.frame_len == 5'h11) && (s_r.frame_len == $past(word_len(s_r.cfg))))
    else $error("word length outside the allowed set");

endmodule

// [adcsm_host_model.sv]
`timescale 1ns/10ps
// ----------------------------------------
// Host side of the serial link
// ----------------------------------------
module adcsm_host_model (
  input wire logic data_out,
  input wire logic data_oe,
  output adcsm_pkg::adcsm_pin_t pins
);
  initial begin
    pins = '{conversion_clock: 1'b0, serial_instruction_in: 1'b0, sclk: 1'b0, cs_n: 1'b1};
    // Free-running 20 MHz, keeps calibration short
    forever #25 pins.conversion_clock = ~pins.conversion_clock;
  end

  task automatic frame(input logic [7:0] instr, input int nbits, output logic [16:0] word);
    word = '0;
    pins.cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      pins.serial_instruction_in = (i < 8) ? instr[i] : ~pins.serial_instruction_in;
      #62.5 pins.sclk = 1'b1;
      // Undriven output reads as the wrong bit, so a dropped enable shows
      #31 word = {word[15:0], data_oe ? data_out : ~data_out};
      #31.5 pins.sclk = 1'b0;
    end
    // Shift clock stands still between frames
    #62.5 pins.cs_n = 1'b1;
    pins.serial_instruction_in = ~pins.serial_instruction_in;
  endtask
endmodule

// [adcsm_tb_top.sv]
`timescale 1ns/10ps
module adcsm_tb_top;
  logic clk_sys;
  logic nrst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic data_out;
  logic data_oe;
  adcsm_pkg::adcsm_pin_t pins;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int cur_len;
  logic [31:0] rd;
  logic [16:0] w;
  logic [7:0] ins;
  logic [2:0] ch;

  adcsm_top dut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins(pins),
    .data_out(data_out), .data_oe(data_oe));
  adcsm_host_model host (.data_out(data_out), .data_oe(data_oe), .pins(pins));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic final_report;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Whole run needs about 35k cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ----------------------------------------
  // Bus and link helpers
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    // Only the run timeout ends a stuck wait
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      bus(1'b0, adcsm_pkg::OFS_STAT, 32'h0000_0000, rd);
      k++;
    end while (rd[14] !== 1'b0 && k < 20000);
    if (k == 20000) n_mismatch++;
  endtask

  task automatic send(input logic [7:0] i, input int len);
    host.frame(i, len, w);
    wait_idle();
  endtask

  // Expected word, right-aligned, first bit on the wire highest
  function automatic logic [16:0] word_of(input logic [12:0] r, input logic lg, input logic lsb, input logic soff);
    logic [16:0] v;
    logic [16:0] o;
    int n;
    n = (soff ? 12 : 13) + (lg ? 4 : 0);
    v = soff ? {5'h00, r[11:0]} : {4'h0, r};
    if (lg) v = v << 4;
    o = v;
    if (lsb) for (int i = 0; i < n; i++) o[i] = v[n-1-i];
    return o;
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    bus(1'b0, adcsm_pkg::OFS_STAT, 32'h0000_0000, rd);
    check(rd, 32'h0000_0201);
    bus(1'b0, adcsm_pkg::OFS_TERMS, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    bus(1'b0, 5'h14, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    // Only the low byte lane lands
    avs_byteenable <= 4'h1;
    bus(1'b1, adcsm_pkg::OFS_SAMPLE, 32'h0000_1fab, rd);
    avs_byteenable <= 4'hf;
    bus(1'b0, adcsm_pkg::OFS_SAMPLE, 32'h0000_0000, rd);
    check(rd, 32'h0000_00ab);
    repeat (100) @(posedge clk_sys);
    bus(1'b1, adcsm_pkg::OFS_MEAS, 32'h0800_0010, rd);
    send(8'h20, 13);
    bus(1'b0, adcsm_pkg::OFS_TERMS, 32'h0000_0000, rd);
    check(rd, 32'h0800_0010);
    bus(1'b0, adcsm_pkg::OFS_STAT, 32'h0000_0000, rd);
    check(rd, 32'h0000_0601);
    bus(1'b1, adcsm_pkg::OFS_MEAS, 32'h0000_0020, rd);
    send(8'h40, 13);
    bus(1'b0, adcsm_pkg::OFS_TERMS, 32'h0000_0000, rd);
    check(rd, 32'h0800_0020);
    bus(1'b0, adcsm_pkg::OFS_STAT, 32'h0000_0000, rd);
    check(rd, 32'h0000_0601);
    // Gain term of -2048 halves the offset-corrected sample
    bus(1'b1, adcsm_pkg::OFS_SAMPLE, 32'h0000_0a5c, rd);
    send(8'h00, 13);
    bus(1'b0, adcsm_pkg::OFS_RESULT, 32'h0000_0000, rd);
    check(rd, 32'h0000_051e);
    host.frame(8'h00, 13, w);
    check({15'h0000, w}, 32'h0000_051e);
    wait_idle();
    bus(1'b1, adcsm_pkg::OFS_SAMPLE, 32'h0000_1f00, rd);
    cur_len = 13;
    for (int k = 0; k < 4; k++) begin
      ins = {3'h5, 2'b00, k[1], k[1:0]};
      send(ins, cur_len);
      bus(1'b0, adcsm_pkg::OFS_STAT, 32'h0000_0000, rd);
      check({29'h0, rd[2:0]}, {29'h0, k[1], k[1:0]});
      cur_len = 12 + (k[1] ? 0 : 1) + (cur_len > 13 ? 4 : 0);
      ch = 3'(2 * k + 1);
      ins = {3'h0, k[1], k[0], ch};
      send(ins, cur_len);
      cur_len = 12 + (k[1] ? 0 : 1) + (k[0] ? 4 : 0);
      bus(1'b0, adcsm_pkg::OFS_RESULT, 32'h0000_0000, rd);
      check(rd, {13'h0000, ch, 3'h0, 13'h1f70});
      host.frame(ins, cur_len, w);
      check({15'h0000, w}, {15'h0000, word_of(13'h1f70, k[0], k[1], k[1])});
      wait_idle();
    end
    send(8'h80, cur_len);
    bus(1'b0, adcsm_pkg::OFS_STAT, 32'h0000_0000, rd);
    check({22'h0, rd[9:0]}, 32'h0000_03ff);
    // Convert while powered down keeps the result, yet its format fields land
    bus(1'b1, adcsm_pkg::OFS_SAMPLE, 32'h0000_0000, rd);
    send(8'h00, cur_len);
    cur_len = 12;
    bus(1'b0, adcsm_pkg::OFS_RESULT, 32'h0000_0000, rd);
    check(rd, 32'h0007_1f70);
    send(8'h60, cur_len);
    bus(1'b0, adcsm_pkg::OFS_STAT, 32'h0000_0000, rd);
    check({22'h0, rd[9:0]}, 32'h0000_0207);
    send(8'h00, cur_len);
    bus(1'b0, adcsm_pkg::OFS_RESULT, 32'h0000_0000, rd);
    check(rd, 32'h0000_1ff0);
    host.frame(8'h00, 12, w);
    check({15'h0000, w}, {15'h0000, word_of(13'h1ff0, 1'b0, 1'b0, 1'b1)});
    wait_idle();
    check({31'h0, data_oe}, 32'h0000_0000);
    final_report();
  end
endmodule
